// [earth_fault_stage_logic.sv]
// Start, trip and latch logic of the earth-fault current and voltage stages
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module earth_fault_stage_logic
  import earth_fault_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DFLT
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Front end
  input  wire meas_t       meas,
  input  wire logic        meas_valid,
  input  wire logic [15:0] idmt_op_ms,
  input  wire logic        ext_bin_in,
  // Output routing
  output stage_out_t       stage_out,
  output logic [4:0]       trip_ind,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [31:0]      rdata
);

  // Product of a value and a percentage, for threshold compares
  function automatic logic [23:0] pct(input logic [15:0] v, input logic [7:0] p);
    pct = {8'h00, v} * {16'h0000, p};
  endfunction

  // Fold an angle into -180..179
  function automatic logic signed [10:0] wrap(input logic signed [10:0] a);
    if (a >= HALF_TURN) begin
      wrap = a - FULL_TURN;
    end else if (a < -HALF_TURN) begin
      wrap = a + FULL_TURN;
    end else begin
      wrap = a;
    end
  endfunction

  // Start delay per stage
  function automatic logic [15:0] start_dly(input int k);
    if (k == ST_IHS || k == ST_UHS) begin
      start_dly = 16'(HS_START_MS);
    end else begin
      start_dly = 16'(LS_START_MS);
    end
  endfunction

  logic [CTRL_W-1:0]  ctrl_ff;
  logic signed [7:0]  basic_ff;
  logic [7:0]         ext_ff;
  logic signed [7:0]  corr_ff;
  logic [15:0]        sv_ff [NSTAGE];
  logic [15:0]        op_ff [NSTAGE];
  meas_t              meas_ff;
  logic [15:0]        tick_cnt_ff;
  logic               tick;
  logic [NSTAGE-1:0]  start_ff;
  logic [NSTAGE-1:0]  trip_ff;
  logic [NSTAGE-1:0]  ind_ff;
  logic [NSTAGE-1:0]  cond;
  logic [NSTAGE-1:0]  blk;
  logic [15:0]        op_ms [NSTAGE];
  logic [10:0]        reset_ms;
  logic               sit_ff;
  logic [7:0]         dbl_cnt_ff;
  logic [31:0]        rdata_ff;
  dir_mode_t          mode;
  logic [16:0]        ihs_thr;
  logic               volt_ok;

  assign mode = dir_mode_t'(ctrl_ff[C_MODE +: 2]);

  // Register writes; out-of-range angles are clamped at the edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_ff  <= RST_CTRL;
      basic_ff <= 8'h00;
      ext_ff   <= 8'h00;
      corr_ff  <= 8'h00;
      for (int i = 0; i < NSTAGE; i++) begin
        sv_ff[i] <= RST_SV;
        op_ff[i] <= RST_OP;
      end
    end else if (wr_stb) begin
      if (addr == ADR_CTRL) begin
        ctrl_ff <= wdata[CTRL_W-1:0];
      end
      if (addr == ADR_ANGLE) begin
        if ($signed(wdata[A_BASIC +: 8]) < 8'(BASIC_MIN) &&
            wdata[A_BASIC + 7]) begin
          basic_ff <= 8'(BASIC_MIN);
        end else if (!wdata[A_BASIC + 7]) begin
          basic_ff <= 8'h00;
        end else begin
          basic_ff <= wdata[A_BASIC +: 8];
        end
        ext_ff  <= (wdata[A_EXT +: 8] > EXT_MAX) ? EXT_MAX : wdata[A_EXT +: 8];
        corr_ff <= wdata[A_CORR +: 8];
      end
      for (int i = 0; i < NSTAGE; i++) begin
        if (addr == ADR_SV_BASE + 8'(4 * i)) begin
          sv_ff[i] <= wdata[15:0];
        end
        if (addr == ADR_OP_BASE + 8'(4 * i)) begin
          op_ff[i] <= wdata[15:0];
        end
      end
    end
  end

  // Measurements captured on each evaluation strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meas_ff <= '0;
    end else if (meas_valid) begin
      meas_ff <= meas;
    end
  end

  // Millisecond tick divider
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_cnt_ff <= 16'h0000;
    end else if (tick) begin
      tick_cnt_ff <= 16'h0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end
  assign tick = (tick_cnt_ff == 16'(CYC_PER_MS - 1));

  // Start situation tracking for high-set doubling
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dbl_cnt_ff <= 8'(DBL_WINDOW_MS);
      sit_ff     <= 1'b0;
    end else begin
      if (pct(meas_ff.io, PCT_UNIT) < pct(sv_ff[ST_ILS], PCT_LOW)) begin
        dbl_cnt_ff <= 8'h00;
      end else if (tick && dbl_cnt_ff < 8'(DBL_WINDOW_MS)) begin
        dbl_cnt_ff <= dbl_cnt_ff + 8'h01;
      end
      // Entry wins over exit: both cannot hold at once anyway
      if (pct(meas_ff.io, PCT_UNIT) > pct(sv_ff[ST_ILS], PCT_HIGH) &&
          dbl_cnt_ff < 8'(DBL_WINDOW_MS)) begin
        sit_ff <= 1'b1;
      end else if (pct(meas_ff.io, PCT_UNIT) < pct(sv_ff[ST_ILS], PCT_END)) begin
        sit_ff <= 1'b0;
      end
    end
  end

  assign ihs_thr = (ctrl_ff[C_DBL_EN] && sit_ff) ? {sv_ff[ST_IHS], 1'b0}
                                                 : {1'b0, sv_ff[ST_IHS]};
  assign volt_ok = meas_ff.u0 > sv_ff[ST_UB];

  // Directional current stages: angle and magnitude qualification
  for (genvar k = 0; k < 2; k++) begin : g_cur
    logic signed [10:0] ref_ang;
    logic signed [10:0] d_ang;
    logic signed [10:0] half;
    logic signed [10:0] lo_lim;
    logic signed [16:0] trig;
    logic signed [33:0] prod;
    logic signed [33:0] thr_s;
    logic               ang_ok;
    logic               mag_ok;
    logic               rev;
    logic               nondir;

    assign rev    = ctrl_ff[C_REV + k];
    assign nondir = ctrl_ff[C_NONDIR + k];
    assign half   = ctrl_ff[C_SECT88] ? SECTOR_WIDE : SECTOR_NARROW;

    // Reference angle per mode, turned half a turn for reverse
    always_comb begin
      case (mode)
        MODE_SIN: ref_ang = wrap(SIN_BASIC + 11'(corr_ff));
        MODE_COS: ref_ang = wrap(COS_BASIC + 11'(corr_ff));
        default:  ref_ang = 11'(basic_ff);
      endcase
      if (rev) begin
        ref_ang = wrap(ref_ang + HALF_TURN);
      end
    end

    assign d_ang  = wrap(11'(meas_ff.phi) - ref_ang);
    // Extension only for basic mode at zero basic angle
    assign lo_lim = (mode == MODE_BASIC && basic_ff == 8'sh00)
                  ? half + $signed({3'b000, ext_ff}) : half;
    assign ang_ok = nondir || (d_ang <= half && d_ang >= -lo_lim);

    // Projection of the current onto the reference direction
    always_comb begin
      case (mode)
        MODE_SIN: trig = -17'(meas_ff.sin_q15);
        MODE_COS: trig = 17'(meas_ff.cos_q15);
        default:  trig = 17'sh00000;
      endcase
      if (rev) begin
        trig = -trig;
      end
    end
    assign prod  = $signed({1'b0, meas_ff.io}) * trig;
    assign thr_s = $signed({2'b00, (k == ST_IHS) ? ihs_thr : {1'b0, sv_ff[ST_ILS]}, 15'h0000});

    // Raw magnitude when non-directional, basic or reserved mode, product otherwise
    always_comb begin
      if (nondir || mode == MODE_BASIC || mode == MODE_RSVD) begin
        mag_ok = $signed({18'h00000, meas_ff.io, 15'h0000}) > thr_s;
      end else begin
        mag_ok = prod > thr_s;
      end
    end

    // Voltage deblocking applies to directional and basic alike
    assign cond[k] = !ctrl_ff[C_VONLY] && mag_ok && volt_ok && ang_ok &&
                     !(k == ST_IHS && ctrl_ff[C_IHS_OFF]);
  end

  // Voltage stages
  assign cond[ST_UB]  = volt_ok;
  assign cond[ST_ULS] = ctrl_ff[C_VONLY] && meas_ff.u0 > sv_ff[ST_ULS];
  assign cond[ST_UHS] = ctrl_ff[C_VONLY] && meas_ff.u0 > sv_ff[ST_UHS] &&
                        !ctrl_ff[C_UHS_OFF];

  assign blk = {NSTAGE{ext_bin_in}} & ctrl_ff[C_BLK +: NSTAGE];

  // Operate time per stage; low-set may follow the inverse time
  always_comb begin
    for (int i = 0; i < NSTAGE; i++) begin
      op_ms[i] = op_ff[i];
    end
    if (ctrl_ff[C_IDMT]) begin
      op_ms[ST_ILS] = idmt_op_ms;
    end
  end

  // Selected resetting time
  always_comb begin
    case (ctrl_ff[C_RST_SEL +: 2])
      2'h0:    reset_ms = 11'(RESET_MS_0);
      2'h1:    reset_ms = 11'(RESET_MS_1);
      2'h2:    reset_ms = 11'(RESET_MS_2);
      default: reset_ms = 11'(RESET_MS_3);
    endcase
  end

  // Per-stage timers: elapsed time holds through short gaps
  for (genvar k = 0; k < NSTAGE; k++) begin : g_stage
    logic        act_ff;
    logic [15:0] ela_ff;
    logic [10:0] rcnt_ff;
    logic        live;
    logic        kill;
    logic        trip_ok;

    // Blocked, switched-off and replaced stages drop at once, not after the reset gap
    assign kill = blk[k] ||
                  (k == ST_IHS && ctrl_ff[C_IHS_OFF]) ||
                  (k == ST_UHS && ctrl_ff[C_UHS_OFF]) ||
                  (k < ST_UB && ctrl_ff[C_VONLY]) ||
                  (k > ST_UB && !ctrl_ff[C_VONLY]);
    assign live = cond[k] && !kill;

    always_ff @(posedge core_clk) begin
      if (srst || kill) begin
        act_ff  <= 1'b0;
        ela_ff  <= 16'h0000;
        rcnt_ff <= 11'h000;
      end else if (live) begin
        act_ff  <= 1'b1;
        rcnt_ff <= 11'h000;
        if (tick && ela_ff != 16'hffff) begin
          ela_ff <= ela_ff + 16'h0001;
        end
      end else if (act_ff && tick) begin
        if (rcnt_ff + 11'h001 >= reset_ms) begin
          act_ff  <= 1'b0;
          ela_ff  <= 16'h0000;
          rcnt_ff <= 11'h000;
        end else begin
          rcnt_ff <= rcnt_ff + 11'h001;
        end
      end
    end

    // Inverse time of the low-set yields to a started high-set
    if (k == ST_ILS) begin : g_inh
      assign trip_ok = !(ctrl_ff[C_IDMT] && ctrl_ff[C_INHIBIT] &&
                         start_ff[ST_IHS]);
    end else begin : g_noinh
      assign trip_ok = 1'b1;
    end

    // Start and trip outputs, and the latched trip indication
    always_ff @(posedge core_clk) begin
      if (srst) begin
        start_ff[k] <= 1'b0;
        trip_ff[k]  <= 1'b0;
      end else begin
        start_ff[k] <= act_ff && !kill && ela_ff >= start_dly(k);
        trip_ff[k]  <= act_ff && !kill && trip_ok && ela_ff >= start_dly(k) &&
                       ela_ff >= op_ms[k];
      end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge core_clk) begin
      if (srst) begin
        ind_ff[k] <= 1'b0;
      end else if (trip_ff[k]) begin
        ind_ff[k] <= 1'b1;
      end else if (wr_stb && addr == ADR_STATUS && wdata[S_IND + k]) begin
        ind_ff[k] <= 1'b0;
      end
    end
  end

  // Register reads, answered one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_stb) begin
      rdata_ff <= 32'h00000000;
      if (addr == ADR_CTRL) begin
        rdata_ff <= {12'h000, ctrl_ff};
      end
      if (addr == ADR_ANGLE) begin
        rdata_ff <= {8'h00, corr_ff, ext_ff, basic_ff};
      end
      for (int i = 0; i < NSTAGE; i++) begin
        if (addr == ADR_SV_BASE + 8'(4 * i)) begin
          rdata_ff <= {16'h0000, sv_ff[i]};
          if ((i == ST_IHS && ctrl_ff[C_IHS_OFF]) ||
              (i == ST_UHS && ctrl_ff[C_UHS_OFF])) begin
            rdata_ff <= {16'h0000, SV_OFF_RD};
          end
        end
        if (addr == ADR_OP_BASE + 8'(4 * i)) begin
          rdata_ff <= {16'h0000, op_ff[i]};
        end
      end
      if (addr == ADR_STATUS) begin
        rdata_ff <= {15'h0000, reset_ms >= 11'(RESET_MS_1), sit_ff,
                     ind_ff, trip_ff, start_ff};
      end
      if (addr == ADR_MEAS) begin
        rdata_ff <= {meas_ff.u0, meas_ff.io};
      end
    end
  end

  assign rdata           = rdata_ff;
  assign stage_out.start = start_ff;
  assign stage_out.trip  = trip_ff;
  assign trip_ind        = ind_ff;

endmodule // earth_fault_stage_logic

// [earth_fault_pkg.sv]
// Constants, register map and carrier types of the earth-fault stage logic
// Notes on behaviour
// - Basic-angle stage starts only if current, common voltage and sector angle all qualify.
// - Basic angle accepts minus ninety to zero degrees.
// - Sector half-width is 80 or 88 degrees, both extendable.
// - At zero basic angle the negative side widens by 0 to 90 degrees.
// - Start raises start output; persistence past operate time raises trip output.
// - Trip indication stays latched after the stage resets.
// - Sine/cosine mode compares current times sin or cos of angle.
// - Sine mode acts as basic angle -90, cosine mode as 0.
// - Sine/cosine sector is shifted by correction angle; all conditions together.
// - Each current stage has own direction and may be non-directional.
// - Low-set current stage starts after 70 ms; trips on definite or inverse time.
// - High-set current stage starts after 60 ms; trips on definite time.
// - Blocking input suppresses start and trip of selected current stage.
// - Inhibit switch: high-set start inhibits low-set inverse time.
// - High-set stage out of operation never starts; start value reads 999.
// - Doubling: high-set threshold doubles during start situation (12/150 within 60, 125).
// - Deblocking voltage stage starts after 70 ms; trips on definite time.
// - Voltage-only mode replaces current stages by low/high voltage stages.
// - High-set voltage stage starts after 60 ms; trips on definite time.
// - Blocking input suppresses start and trip of selected voltage stage.
// - Resetting time 80/100/500/1000 ms; from 100 ms low-set is intermittent.
package earth_fault_pkg;

  // Timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int MS_PERIOD_NS    = 1000000;
  localparam int CYC_PER_MS_DFLT = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LS_START_MS     = 70;
  localparam int HS_START_MS     = 60;
  localparam int RESET_MS_0      = 80;
  localparam int RESET_MS_1      = 100;
  localparam int RESET_MS_2      = 500;
  localparam int RESET_MS_3      = 1000;
  localparam int DBL_WINDOW_MS   = 60;

  // Doubling thresholds in percent of low-set start value
  localparam logic [7:0] PCT_LOW  = 8'h0c;   // 12 %
  localparam logic [7:0] PCT_HIGH = 8'h96;   // 150 %
  localparam logic [7:0] PCT_END  = 8'h7d;   // 125 %
  localparam logic [7:0] PCT_UNIT = 8'h64;   // 100 %

  // Angles in degrees
  localparam logic signed [10:0] BASIC_MIN   = -11'sd90;
  localparam logic signed [10:0] SIN_BASIC   = -11'sd90;
  localparam logic signed [10:0] COS_BASIC   = 11'sd0;
  localparam logic        [7:0]  EXT_MAX     = 8'h5a;
  localparam logic signed [10:0] SECTOR_NARROW = 11'sd80;
  localparam logic signed [10:0] SECTOR_WIDE   = 11'sd88;
  localparam logic signed [10:0] HALF_TURN   = 11'sd180;
  localparam logic signed [10:0] FULL_TURN   = 11'sd360;

  // Stage indices
  localparam int NSTAGE  = 5;
  localparam int ST_ILS  = 0;
  localparam int ST_IHS  = 1;
  localparam int ST_UB   = 2;
  localparam int ST_ULS  = 3;
  localparam int ST_UHS  = 4;

  // Register byte addresses
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_ANGLE   = 8'h04;
  localparam logic [7:0] ADR_SV_BASE = 8'h08;  // five start values, one per stage
  localparam logic [7:0] ADR_OP_BASE = 8'h1c;  // five operate times in ms
  localparam logic [7:0] ADR_STATUS  = 8'h30;
  localparam logic [7:0] ADR_MEAS    = 8'h34;

  // Control field positions
  localparam int C_MODE     = 0;   // 2 bits: 0 basic, 1 sine, 2 cosine
  localparam int C_SECT88   = 2;
  localparam int C_VONLY    = 3;
  localparam int C_INHIBIT  = 4;
  localparam int C_DBL_EN   = 5;
  localparam int C_IDMT     = 6;
  localparam int C_RST_SEL  = 7;   // 2 bits
  localparam int C_REV      = 9;   // 2 bits, current stages
  localparam int C_NONDIR   = 11;  // 2 bits, current stages
  localparam int C_IHS_OFF  = 13;
  localparam int C_UHS_OFF  = 14;
  localparam int C_BLK      = 15;  // 5 bits, one per stage
  localparam int CTRL_W     = 20;

  // Angle register field positions
  localparam int A_BASIC = 0;
  localparam int A_EXT   = 8;
  localparam int A_CORR  = 16;

  // Status field positions
  localparam int S_START = 0;
  localparam int S_TRIP  = 5;
  localparam int S_IND   = 10;
  localparam int S_SIT   = 15;
  localparam int S_INTER = 16;

  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL  = 20'h00000;
  localparam logic [15:0]       RST_SV    = 16'h0014;  // 2.0 % in 0.1 % steps
  localparam logic [15:0]       RST_OP    = 16'h0064;  // 100 ms
  localparam logic [15:0]       SV_OFF_RD = 16'h03e7;  // read-back when out of operation

  typedef enum logic [1:0] {MODE_BASIC, MODE_SIN, MODE_COS, MODE_RSVD} dir_mode_t;

  // Measurement set from the front end
  typedef struct packed {
    logic        [15:0] io;       // earth-fault current, 0.1 % steps
    logic        [15:0] u0;       // zero-sequence voltage, 0.1 % steps
    logic signed [8:0]  phi;      // phase angle, degrees
    logic signed [15:0] sin_q15;  // sine of phi, Q15
    logic signed [15:0] cos_q15;  // cosine of phi, Q15
  } meas_t;

  // Stage outputs to output routing
  typedef struct packed {
    logic [NSTAGE-1:0] start;
    logic [NSTAGE-1:0] trip;
  } stage_out_t;

endpackage

// [ef_front_end.sv]
// Front-end model: current, voltage, angle and its sine and cosine
`timescale 1ns/1ps
module ef_front_end
  import earth_fault_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Quantities chosen by the bench
  input  wire logic [15:0]       io,
  input  wire logic [15:0]       u0,
  input  wire logic signed [8:0] phi,
  // Toward the stage logic
  output meas_t                  meas,
  output logic                   meas_valid
);
  // Fresh sample on every clock, so no stale angle lingers
  always_ff @(posedge core_clk) begin
    meas_valid   <= !srst;
    meas.io      <= io;
    meas.u0      <= u0;
    meas.phi     <= phi;
    meas.sin_q15 <= 16'($rtoi($sin(real'(phi) * 3.14159265 / 180.0) * 32767.0));
    meas.cos_q15 <= 16'($rtoi($cos(real'(phi) * 3.14159265 / 180.0) * 32767.0));
  end
endmodule // ef_front_end

// [ef_stage_sva.sv]
// Port-level assertions for the earth-fault stage logic
`timescale 1ns/1ps
module ef_stage_sva
  import earth_fault_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DFLT
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Stage side
  input wire logic        ext_bin_in,
  input wire stage_out_t  stage_out,
  input wire logic [4:0]  trip_ind,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata
);
  // Control shadow, since block and off bits never reach the ports
  logic [CTRL_W-1:0] ctrl_ff;
  always_ff @(posedge core_clk) begin
    if (srst) ctrl_ff <= RST_CTRL;
    else if (wr_stb && addr == ADR_CTRL) ctrl_ff <= wdata[CTRL_W-1:0];
  end
  wire logic [4:0] blk = ctrl_ff[C_BLK +: 5];
  wire logic [4:0] act = stage_out.start | stage_out.trip;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  rst_clear_a: assert property (disable iff (1'b0) srst |=> act == 5'h00)
    else $error("stage outputs left set by reset");
  trip_start_a: assert property ((stage_out.trip & ~stage_out.start) == 5'h00)
    else $error("trip without start");
  ind_set_a: assert property (stage_out.trip != 5'h00 |=>
    (trip_ind & $past(stage_out.trip)) == $past(stage_out.trip))
    else $error("trip indication not set");
  ind_hold_a: assert property (!$past(srst) && (~trip_ind & $past(trip_ind)) != 5'h00 |->
    $past(wr_stb) && $past(addr) == ADR_STATUS)
    else $error("trip indication dropped without clear");
  block_a: assert property (ext_bin_in |=> (act & $past(blk)) == 5'h00)
    else $error("blocked stage active");
  hs_off_a: assert property ($past(ctrl_ff[C_IHS_OFF]) |-> !act[ST_IHS])
    else $error("high-set stage active while off");
  off_read_a: assert property (rd_stb && addr == 8'h0c && ctrl_ff[C_IHS_OFF] |=>
    rdata[15:0] == SV_OFF_RD)
    else $error("off start value read back wrong");
  vonly_a: assert property ($past(ctrl_ff[C_VONLY]) && $past(ctrl_ff[C_VONLY], 2) |->
    act[1:0] == 2'b00)
    else $error("current stage active in voltage-only mode");

  // Main scenarios reached
  cover property (stage_out.trip[ST_ILS]);
  cover property (ext_bin_in && blk != 5'h00);
  cover property ($fell(trip_ind[ST_ILS]));
endmodule // ef_stage_sva

bind earth_fault_stage_logic ef_stage_sva #(.CYC_PER_MS(CYC_PER_MS)) ef_stage_sva_i (
  .core_clk(core_clk), .srst(srst), .ext_bin_in(ext_bin_in), .stage_out(stage_out),
  .trip_ind(trip_ind), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata)
);

// [tb.sv]
// Self-checking bench for the earth-fault stage logic
`timescale 1ns/1ps
module tb;
  import earth_fault_pkg::*;
  // Short millisecond keeps the run small; every ms wait scales with it, while the reset hold, access cycles and the watchdog count raw cycles
  localparam int CPM = 4;
  localparam int CTRL_T [12] = '{0, 0, 4, 4, 0, 0, 2048, 512, 0, 1, 2, 2};
  localparam int ANG_T [12] = '{0, 0, 0, 0, 10240, 0, 0, 0, 166, 0, 0, 0};
  localparam int PHI_T [12] = '{79, 85, 85, 95, -110, -110, 180, 180, -90, -90, -60, 0};
  localparam logic [11:0] EXP_T = 12'hbd5;

  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic [15:0]       io = 16'h0000;
  logic [15:0]       u0 = 16'h0000;
  logic signed [8:0] phi = 9'sh000;
  logic              ext_bin_in = 1'b0;
  logic [7:0]        addr = 8'h00;
  logic [31:0]       wdata = 32'h0000_0000;
  logic              wr_stb = 1'b0;
  logic              rd_stb = 1'b0;
  meas_t             meas;
  logic              meas_valid;
  stage_out_t        stage_out;
  logic [4:0]        trip_ind;
  logic [31:0]       rdata;
  int                err_total = 0;
  int                n_tests = 0;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  ef_front_end ef_front_end_i (
    .core_clk(core_clk), .srst(srst), .io(io), .u0(u0), .phi(phi),
    .meas(meas), .meas_valid(meas_valid)
  );
  earth_fault_stage_logic #(.CYC_PER_MS(CPM)) earth_fault_stage_logic_i (
    .core_clk(core_clk), .srst(srst), .meas(meas), .meas_valid(meas_valid),
    .idmt_op_ms(16'h0032), .ext_bin_in(ext_bin_in), .stage_out(stage_out),
    .trip_ind(trip_ind), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic ms(input int n);
    repeat (n * CPM) @(posedge core_clk);
  endtask

  // Idle cycle after each write so the strobe is never re-driven in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
    @(posedge core_clk);
  endtask

  // Wait, then judge start, trip and latched indication together
  task automatic outs(input int n, input logic [4:0] s, input logic [4:0] t, input logic [4:0] i);
    ms(n);
    #1;
    chk("stage outputs", {17'h0, s, t, i}, {17'h0, stage_out, trip_ind});
    @(posedge core_clk);
  endtask

  task automatic fault(input logic [15:0] i, input logic [15:0] u, input int p);
    io <= i;
    u0 <= u;
    phi <= 9'(p);
  endtask

  task automatic quiet;
    fault(16'h0000, 16'h0000, 0);
    ext_bin_in <= 1'b0;
    ms(100);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_STATUS, 32'h7c00);
  endtask

  task automatic t_regs;
    rd(ADR_CTRL, 32'h0);
    rd(ADR_SV_BASE, {16'h0, RST_SV});
    rd(ADR_OP_BASE, {16'h0, RST_OP});
    wr(ADR_ANGLE, 32'h5);
    rd(ADR_ANGLE, 32'h0);
    wr(ADR_ANGLE, 32'h649c);
    rd(ADR_ANGLE, 32'h5aa6);
    rd(8'hfc, 32'h0);
    wr(ADR_CTRL, 32'h80);
    rd(ADR_STATUS, 32'h0001_0000);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_ANGLE, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_ils;
    wr(ADR_SV_BASE, 32'h96);
    wr(ADR_SV_BASE + 8'h04, 32'h7fff);
    wr(ADR_SV_BASE + 8'h08, 32'h32);
    fault(16'h00c8, 16'h0064, 0);
    outs(66, 5'h00, 5'h00, 5'h00);
    outs(8, 5'h05, 5'h00, 5'h00);
    outs(22, 5'h05, 5'h00, 5'h00);
    outs(8, 5'h05, 5'h05, 5'h05);
    fault(16'h0000, 16'h0000, 0);
    outs(95, 5'h00, 5'h00, 5'h05);
    wr(ADR_STATUS, 32'h7c00);
    outs(0, 5'h00, 5'h00, 5'h00);
    $display("t_ils done");
  endtask

  // Sector edges, extension, reverse, non-directional, sine and cosine
  task automatic t_angles;
    for (int k = 0; k < 12; k++) begin
      wr(ADR_CTRL, 32'(CTRL_T[k]));
      wr(ADR_ANGLE, 32'(ANG_T[k]));
      fault(16'h00c8, 16'h0064, PHI_T[k]);
      outs(74, {4'h2, EXP_T[k]}, 5'h00, 5'h00);
      fault(16'h0000, 16'h0000, 0);
      ms(95);
    end
    quiet();
    $display("t_angles done");
  endtask

  task automatic t_block;
    wr(ADR_CTRL, 32'h0002_8000);
    ext_bin_in <= 1'b1;
    fault(16'h00c8, 16'h0064, 0);
    outs(110, 5'h00, 5'h00, 5'h00);
    ext_bin_in <= 1'b0;
    outs(66, 5'h00, 5'h00, 5'h00);
    outs(8, 5'h05, 5'h00, 5'h00);
    quiet();
    $display("t_block done");
  endtask

  task automatic t_hs;
    wr(ADR_SV_BASE + 8'h04, 32'h64);
    wr(ADR_CTRL, 32'h1000);
    fault(16'h00c8, 16'h0064, 0);
    outs(56, 5'h00, 5'h00, 5'h00);
    outs(8, 5'h02, 5'h00, 5'h00);
    wr(ADR_CTRL, 32'h3000);
    rd(ADR_SV_BASE + 8'h04, 32'h3e7);
    outs(0, 5'h00, 5'h00, 5'h00);
    quiet();
    $display("t_hs done");
  endtask

  // Inverse time, its inhibit by the high-set start, and inrush doubling
  task automatic t_idmt;
    wr(ADR_CTRL, 32'h40);
    fault(16'h00c8, 16'h0064, 0);
    outs(74, 5'h07, 5'h01, 5'h01);
    quiet();
    wr(ADR_CTRL, 32'h50);
    fault(16'h00c8, 16'h0064, 0);
    outs(74, 5'h07, 5'h00, 5'h00);
    quiet();
    wr(ADR_SV_BASE + 8'h04, 32'hc8);
    wr(ADR_CTRL, 32'h20);
    fault(16'h012c, 16'h0064, 0);
    ms(1);
    rd(ADR_STATUS, 32'h8000);
    outs(62, 5'h00, 5'h00, 5'h00);
    quiet();
    $display("t_idmt done");
  endtask

  task automatic t_vonly;
    wr(ADR_SV_BASE + 8'h0c, 32'h50);
    wr(ADR_SV_BASE + 8'h10, 32'h5a);
    wr(ADR_CTRL, 32'h8);
    fault(16'h00c8, 16'h0064, 0);
    outs(56, 5'h00, 5'h00, 5'h00);
    outs(8, 5'h10, 5'h00, 5'h00);
    outs(10, 5'h1c, 5'h00, 5'h00);
    wr(ADR_CTRL, 32'h4008);
    rd(ADR_SV_BASE + 8'h10, 32'h3e7);
    quiet();
    $display("t_vonly done");
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_ils();
    t_angles();
    t_block();
    t_hs();
    t_idmt();
    t_vonly();
    summarize();
  end

  // Watchdog: about twice the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    err_total++;
    summarize();
  end
endmodule // tb
